/* prat_alarm_top.sv */
// protective relay alarm timing: var, imbalance, sync, bias, mismatch
// Overview of operation
// - reactive power relay is definite time against set trigger levels
// - generator over is var out; bus export is var into bus
// - every alarm stays latched until the controller reset
// - pre and alarm delays separate; forward/reverse share; gen/bus apart
// - action only after level stays beyond trigger for the whole delay
// - imbalance is the largest of the three phase pair differences
// - imbalance must persist for the inverse delay, recalculated always
// - imbalance relay always on, one shift for pre and alarm
// - rated current added to measured imbalance; ratio taken against rated
// - close only while synchronizing and only with phases in sync
// - permissive mode closes whenever synchronizing with the sources in sync
// - high and low limit alarms per bias output after 10 s
// - digital bias: demand with no response counts as at limit
// - expected frequency is rpm times poles over 120
// - mismatch alarm when beyond 1 Hz margin for 5 s
// - delay is (A over x squared minus one plus B) times D
// - shift D clamps to 0.01..10.0, zero gives 0.01, scales time only
// - curve input x is measured over rated
// - high alarm: pre and alarm act after their curve timeouts
// - low alarm: acts after curve timeout once below level
// - at or below rated the curve is a fixed 10 s times D
// - one curve shape; imbalance pre and alarm share one shift
`timescale 1ns/1ns
`include "prat_consts.svh"
module prat_alarm_top #(
    parameter int TICK_CYC = `PRAT_TICK_CYC
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic alarm_reset,
    // reactive power, signed, positive out of gen / into bus
    input wire logic signed [15:0] var_gen,
    input wire logic signed [15:0] var_bus,
    // var levels: over pre, over alarm, reverse pre, reverse alarm
    input wire logic [15:0] gen_var_lvl [4],
    input wire logic [15:0] bus_var_lvl [4],
    // var delays in ms
    input wire logic [15:0] gen_pre_dly,
    input wire logic [15:0] gen_alm_dly,
    input wire logic [15:0] bus_pre_dly,
    input wire logic [15:0] bus_alm_dly,
    // phase currents and imbalance settings
    input wire logic [15:0] cur_a,
    input wire logic [15:0] cur_b,
    input wire logic [15:0] cur_c,
    input wire logic [15:0] rated_cur,
    input wire logic [15:0] imb_pre_lvl,
    input wire logic [15:0] imb_alm_lvl,
    input wire logic [9:0] imb_shift,
    // synchronizer
    input wire logic synchronizing,
    input wire logic permissive_mode,
    input wire logic phases_in_sync,
    input wire logic close_request,
    // bias outputs: volt hi, volt lo, speed hi, speed lo
    input wire logic [3:0] bias_at_limit,
    input wire logic [3:0] bias_demand,
    input wire logic [1:0] bias_responding,
    input wire logic bias_digital,
    // speed and frequency, rpm and 0.01 Hz
    input wire logic [15:0] speed_pickup_sensor,
    input wire logic [15:0] gen_freq,
    input wire logic [7:0] gen_poles,
    // action code of each alarm
    input wire logic [1:0] action_cfg [`PRAT_N_ALM],
    // results
    output logic [`PRAT_N_ALM-1:0] alarms,
    output logic [1:0] worst_action,
    output logic breaker_close
);
    logic [16:0] tick_cnt_q;
    logic tick_q;
    logic [15:0] gen_over;
    logic [15:0] gen_rev;
    logic [15:0] bus_exp;
    logic [15:0] bus_imp;
    logic [15:0] d_ab;
    logic [15:0] d_bc;
    logic [15:0] d_ca;
    logic [15:0] imb_max;
    logic [9:0] imb_d;
    logic [`PRAT_N_DEF-1:0] def_cond;
    logic [31:0] def_dly [`PRAT_N_DEF];
    logic [`PRAT_N_DEF-1:0] def_alm_q;
    logic [31:0] def_cnt_q [`PRAT_N_DEF];
    logic [1:0] imb_alm;
    logic [31:0] exp_freq;
    logic [31:0] freq_diff;
    logic [3:0] lim_cond;
    logic [1:0] worst_d;
    logic close_q;

    // 1 ms evaluation tick
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            tick_cnt_q <= 17'h00000;
            tick_q <= 1'b0;
        end else if (tick_cnt_q == 17'(TICK_CYC - 1)) begin
            tick_cnt_q <= 17'h00000;
            tick_q <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 17'h00001;
            tick_q <= 1'b0;
        end
    end

    // directional magnitudes, reactive power only
    always_comb begin
        gen_over = var_gen > 0 ? 16'(var_gen) : 16'h0000;
        gen_rev = var_gen < 0 ? 16'(-var_gen) : 16'h0000;
        bus_exp = var_bus > 0 ? 16'(var_bus) : 16'h0000;
        bus_imp = var_bus < 0 ? 16'(-var_bus) : 16'h0000;
    end

    // definite-time conditions and delays
    always_comb begin
        def_cond[0] = gen_over > gen_var_lvl[0];
        def_cond[1] = gen_over > gen_var_lvl[1];
        def_cond[2] = gen_rev > gen_var_lvl[2];
        def_cond[3] = gen_rev > gen_var_lvl[3];
        def_cond[4] = bus_exp > bus_var_lvl[0];
        def_cond[5] = bus_exp > bus_var_lvl[1];
        def_cond[6] = bus_imp > bus_var_lvl[2];
        def_cond[7] = bus_imp > bus_var_lvl[3];
        def_dly[0] = {16'h0000, gen_pre_dly};
        def_dly[1] = {16'h0000, gen_alm_dly};
        def_dly[2] = {16'h0000, gen_pre_dly};
        def_dly[3] = {16'h0000, gen_alm_dly};
        def_dly[4] = {16'h0000, bus_pre_dly};
        def_dly[5] = {16'h0000, bus_alm_dly};
        def_dly[6] = {16'h0000, bus_pre_dly};
        def_dly[7] = {16'h0000, bus_alm_dly};
        for (int i = 0; i < 4; i++) begin
            def_cond[8 + i] = lim_cond[i];
            def_dly[8 + i] = 32'(`PRAT_BIAS_TO_MS);
        end
        def_cond[12] = freq_diff > 32'(`PRAT_MISM_MARGIN);
        def_dly[12] = 32'(`PRAT_MISM_TO_MS);
    end

    // bias limit: analog at limit or digital demand left unanswered
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            lim_cond[i] = bias_at_limit[i]
                | (bias_digital & bias_demand[i] & ~bias_responding[i / 2]);
        end
    end

    // expected frequency from pickup rpm and poles
    always_comb begin
        exp_freq = ({16'h0000, speed_pickup_sensor} * {24'h000000, gen_poles}
            * 32'(`PRAT_D_SCALE)) / 32'(`PRAT_FREQ_CONST);
        if (exp_freq > {16'h0000, gen_freq}) begin
            freq_diff = exp_freq - {16'h0000, gen_freq};
        end else begin
            freq_diff = {16'h0000, gen_freq} - exp_freq;
        end
    end

    // definite-time channels, each a restartable timer and latch
    for (genvar g = 0; g < `PRAT_N_DEF; g++) begin : g_def
        always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
                def_cnt_q[g] <= 32'h0000_0000;
            end else if (!def_cond[g] || def_alm_q[g]) begin
                def_cnt_q[g] <= 32'h0000_0000;
            end else if (tick_q) begin
                def_cnt_q[g] <= def_cnt_q[g] + 32'h0000_0001;
            end
        end
        always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
                def_alm_q[g] <= 1'b0;
            end else if (def_cond[g] && tick_q && def_cnt_q[g] + 32'h1 >= def_dly[g]) begin
                def_alm_q[g] <= 1'b1;
            end else if (alarm_reset) begin
                def_alm_q[g] <= 1'b0;
            end
        end
    end

    // shared imbalance shift, clamped to its range
    always_comb begin
        if (imb_shift < `PRAT_D_MIN) begin
            imb_d = `PRAT_D_MIN;
        end else if (imb_shift > `PRAT_D_MAX) begin
            imb_d = `PRAT_D_MAX;
        end else begin
            imb_d = imb_shift;
        end
    end

    // largest phase pair difference
    always_comb begin
        d_ab = cur_a > cur_b ? cur_a - cur_b : cur_b - cur_a;
        d_bc = cur_b > cur_c ? cur_b - cur_c : cur_c - cur_b;
        d_ca = cur_c > cur_a ? cur_c - cur_a : cur_a - cur_c;
        imb_max = d_ab;
        if (d_bc > imb_max) begin
            imb_max = d_bc;
        end
        if (d_ca > imb_max) begin
            imb_max = d_ca;
        end
    end

    // imbalance pre-alarm and alarm on one curve and one shift
    prat_inv_relay #(.LOW_ALARM(1'b0)) u_imb_pre (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .tick(tick_q),
        .alarm_reset(alarm_reset),
        .meas(imb_max),
        .rated(rated_cur),
        .level(imb_pre_lvl),
        .shift_d(imb_d),
        .add_rated(1'b1),
        .alarm(imb_alm[0]),
        .timing()
    );
    prat_inv_relay #(.LOW_ALARM(1'b0)) u_imb_alm (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .tick(tick_q),
        .alarm_reset(alarm_reset),
        .meas(imb_max),
        .rated(rated_cur),
        .level(imb_alm_lvl),
        .shift_d(imb_d),
        .add_rated(1'b1),
        .alarm(imb_alm[1]),
        .timing()
    );

    // sync check gate on the breaker close
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            close_q <= 1'b0;
        end else begin
            close_q <= synchronizing && phases_in_sync
                && (permissive_mode || close_request);
        end
    end
    assign breaker_close = close_q;

    // alarm vector and the most severe action of latched alarms
    assign alarms = {def_alm_q[12], def_alm_q[11:8], imb_alm, def_alm_q[7:0]};
    always_comb begin
        worst_d = 2'h0;
        for (int i = 0; i < `PRAT_N_ALM; i++) begin
            if (alarms[i] && action_cfg[i] > worst_d) begin
                worst_d = action_cfg[i];
            end
        end
    end
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            worst_action <= 2'h0;
        end else begin
            worst_action <= worst_d;
        end
    end

    // tick spacing
    tick_period_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        tick_q |=> !tick_q)
        else $error("tick lasted more than one cycle");
    var_latch_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        def_alm_q[0] && !alarm_reset |=> def_alm_q[0])
        else $error("var alarm dropped without reset");
    var_cause_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        $rose(def_alm_q[1]) |-> $past(def_cond[1]) && $past(tick_q))
        else $error("var alarm set without cause");
    var_restart_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        !def_cond[4] |=> def_cnt_q[4] == 32'h0000_0000)
        else $error("var timer kept count");
    close_gate_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        breaker_close |-> $past(phases_in_sync) && $past(synchronizing))
        else $error("close without sync");
    close_perm_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        synchronizing && permissive_mode && phases_in_sync |=> breaker_close)
        else $error("permissive close missing");
    bias_time_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        $rose(def_alm_q[8]) |-> $past(def_cnt_q[8]) == 32'(`PRAT_BIAS_TO_MS - 1))
        else $error("bias alarm not at 10 s");
    mism_time_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        $rose(def_alm_q[12]) |-> $past(def_cnt_q[12]) == 32'(`PRAT_MISM_TO_MS - 1))
        else $error("mismatch alarm not at 5 s");
    shift_rng_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        imb_d >= `PRAT_D_MIN && imb_d <= `PRAT_D_MAX)
        else $error("shift outside range");
endmodule : prat_alarm_top

/* prat_consts.svh */
// constants of the protective relay alarm timing block
`ifndef PRAT_CONSTS_SVH
`define PRAT_CONSTS_SVH
// clock period and the evaluation tick
`define PRAT_CLK_NS 8
`define PRAT_TICK_NS 1000000
`define PRAT_TICK_CYC (`PRAT_TICK_NS / `PRAT_CLK_NS)
// inverse-time curve, times in ms, p fixed at 2
`define PRAT_CRV_A_MS 19610
`define PRAT_CRV_B_MS 491
`define PRAT_CRV_P 2
// curve at or below rated: A becomes 0, B becomes 10 s
`define PRAT_FIX_A_MS 0
`define PRAT_FIX_B_MS 10000
// ratio fraction bits and unity
`define PRAT_X_FRAC 8
`define PRAT_X_ONE 256
// curve shift in hundredths: 0.01 .. 10.0, default 1.0
`define PRAT_D_MIN 10'h001
`define PRAT_D_MAX 10'h3e8
`define PRAT_D_DEF 10'h064
`define PRAT_D_SCALE 100
// fixed timeouts in ms
`define PRAT_BIAS_TO_MS 10000
`define PRAT_MISM_TO_MS 5000
// mismatch margin in 0.01 Hz and the pole constant
`define PRAT_MISM_MARGIN 100
`define PRAT_FREQ_CONST 120
// alarm counts
`define PRAT_N_DEF 13
`define PRAT_N_ALM 15
`endif

/* prat_pkg.sv */
// types of the protective relay alarm timing block
package prat_pkg;
    // timer states, gray along idle, timing, tripped
    typedef enum logic [1:0] {
        PRAT_IDLE = 2'b00,
        PRAT_TIMING = 2'b01,
        PRAT_TRIPPED = 2'b11
    } prat_tstate_t;
endpackage : prat_pkg

/* prat_inv_relay.sv */
// one inverse-time relay level with latched alarm
`timescale 1ns/1ns
`include "prat_consts.svh"
module prat_inv_relay #(
    parameter bit LOW_ALARM = 1'b0
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // timing
    input wire logic tick,
    input wire logic alarm_reset,
    // measurement and settings
    input wire logic [15:0] meas,
    input wire logic [15:0] rated,
    input wire logic [15:0] level,
    input wire logic [9:0] shift_d,
    input wire logic add_rated,
    // result
    output logic alarm,
    output logic timing
);
    prat_pkg::prat_tstate_t st_q;
    logic [31:0] cnt_q;
    logic [16:0] eff;
    logic [31:0] x_q8;
    logic [63:0] x_sq;
    logic [63:0] base_ms;
    logic [63:0] time_ms;
    logic beyond;
    logic fixed;

    // ratio of measured to rated, rated optionally added
    always_comb begin
        eff = add_rated ? ({1'b0, meas} + {1'b0, rated}) : {1'b0, meas};
        if (rated == 16'h0000) begin
            x_q8 = 32'h0000_0000;
        end else begin
            x_q8 = ({15'h0000, eff} << `PRAT_X_FRAC) / {16'h0000, rated};
        end
        x_sq = {32'h0000_0000, x_q8} * {32'h0000_0000, x_q8};
        fixed = (x_q8 <= 32'(`PRAT_X_ONE));
    end

    // delay recalculated every cycle from present level
    always_comb begin
        if (fixed) begin
            base_ms = 64'(`PRAT_FIX_A_MS) + 64'(`PRAT_FIX_B_MS);
        end else begin
            base_ms = (64'(`PRAT_CRV_A_MS) << (2 * `PRAT_X_FRAC))
                / (x_sq - 64'(`PRAT_X_ONE * `PRAT_X_ONE)) + 64'(`PRAT_CRV_B_MS);
        end
        time_ms = base_ms * {54'h0, shift_d} / 64'(`PRAT_D_SCALE);
    end

    // high alarms trip above level, low alarms below
    assign beyond = LOW_ALARM ? (meas < level) : (meas > level);

    // timer, restarted when the input comes back inside
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st_q <= prat_pkg::PRAT_IDLE;
            cnt_q <= 32'h0000_0000;
        end else begin
            case (st_q)
                prat_pkg::PRAT_IDLE: begin
                    cnt_q <= 32'h0000_0000;
                    if (beyond) begin
                        st_q <= prat_pkg::PRAT_TIMING;
                    end
                end
                prat_pkg::PRAT_TIMING: begin
                    if (!beyond) begin
                        st_q <= prat_pkg::PRAT_IDLE;
                        cnt_q <= 32'h0000_0000;
                    end else if (tick) begin
                        cnt_q <= cnt_q + 32'h0000_0001;
                        if ({32'h0, cnt_q} + 64'h1 >= time_ms) begin
                            st_q <= prat_pkg::PRAT_TRIPPED;
                        end
                    end
                end
                prat_pkg::PRAT_TRIPPED: begin
                    if (alarm_reset) begin
                        st_q <= prat_pkg::PRAT_IDLE;
                        cnt_q <= 32'h0000_0000;
                    end
                end
                default: begin
                    st_q <= prat_pkg::PRAT_IDLE;
                    cnt_q <= 32'h0000_0000;
                end
            endcase
        end
    end

    assign alarm = (st_q == prat_pkg::PRAT_TRIPPED);
    assign timing = (st_q == prat_pkg::PRAT_TIMING);

    // alarm only after time spent timing
    inv_latch_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        alarm && !alarm_reset |=> alarm)
        else $error("inverse alarm dropped without reset");
    inv_restart_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        timing && !beyond |=> cnt_q == 32'h0000_0000)
        else $error("inverse timer not restarted");
    inv_trip_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        !alarm ##1 alarm |-> $past(timing) && $past(beyond) && $past(tick))
        else $error("inverse trip without timing tick");
endmodule : prat_inv_relay

/* prat_meas_model.sv */
// measurement front end model feeding the relay alarm block
`timescale 1ns/1ns
module prat_meas_model (
    // clock
    input wire logic ref_clk,
    // commanded plant values
    input wire logic signed [15:0] var_gen_cmd,
    input wire logic signed [15:0] var_bus_cmd,
    input wire logic [15:0] cur_cmd [3],
    input wire logic [15:0] rpm_cmd,
    input wire logic [15:0] freq_cmd,
    // measured values towards the block
    output logic signed [15:0] var_gen,
    output logic signed [15:0] var_bus,
    output logic [15:0] cur_a,
    output logic [15:0] cur_b,
    output logic [15:0] cur_c,
    output logic [15:0] speed_pickup_sensor,
    output logic [15:0] gen_freq
);
    // a new measurement lands one clock after it is commanded, one driver per output
    always @(posedge ref_clk) begin
        var_gen <= var_gen_cmd;
        var_bus <= var_bus_cmd;
        cur_a <= cur_cmd[0];
        cur_b <= cur_cmd[1];
        cur_c <= cur_cmd[2];
        speed_pickup_sensor <= rpm_cmd;
        gen_freq <= freq_cmd;
    end
endmodule : prat_meas_model

/* testbench.sv */
// self-checking bench for the protective relay alarm timing block
`timescale 1ns/1ns
`include "prat_consts.svh"
module testbench;
    localparam int TC = 2;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic alarm_reset = 1'b0;
    logic signed [15:0] var_gen_cmd = 16'sh0000;
    logic signed [15:0] var_bus_cmd = 16'sh0000;
    logic [15:0] cur_cmd [3] = '{16'h01f4, 16'h01f4, 16'h01f4};
    logic [15:0] rpm_cmd = 16'h0bb8;
    logic [15:0] freq_cmd = 16'h1388;
    logic signed [15:0] var_gen, var_bus;
    logic [15:0] cur_a, cur_b, cur_c, speed_pickup_sensor, gen_freq;
    logic [15:0] gen_var_lvl [4] = '{16'h0064, 16'h00c8, 16'h0064, 16'h00c8};
    logic [15:0] bus_var_lvl [4] = '{16'h0064, 16'h00c8, 16'h0064, 16'h00c8};
    logic [15:0] gen_pre_dly = 16'h0005;
    logic [15:0] gen_alm_dly = 16'h0008;
    logic [15:0] bus_pre_dly = 16'h000c;
    logic [15:0] bus_alm_dly = 16'h0003;
    logic [15:0] rated_cur = 16'h0000;
    logic [15:0] imb_pre_lvl = 16'h0028;
    logic [15:0] imb_alm_lvl = 16'h03e8;
    logic [9:0] imb_shift = 10'h000;
    logic synchronizing = 1'b0, permissive_mode = 1'b0;
    logic phases_in_sync = 1'b0, close_request = 1'b0;
    logic [3:0] bias_at_limit = 4'h0;
    logic [3:0] bias_demand = 4'h0;
    logic [1:0] bias_responding = 2'h0;
    logic bias_digital = 1'b0;
    logic [7:0] gen_poles = 8'h02;
    logic [1:0] action_cfg [`PRAT_N_ALM] = '{0: 2'h1, 1: 2'h3, default: 2'h0};
    logic [`PRAT_N_ALM-1:0] alarms;
    logic [1:0] worst_action;
    logic breaker_close;
    int miscompares = 0;
    int checks_done = 0;
    int cyc = 0;
    // imbalance patterns: the pair 50 apart moves around, shift and expected ticks
    logic [15:0] imb_pat [3][3] = '{'{500, 530, 550}, '{550, 500, 530}, '{530, 550, 500}};
    logic [9:0] imb_d [3] = '{10'h000, 10'h002, 10'h001};
    int imb_t [3] = '{100, 200, 100};

    // plant measurement front end
    prat_meas_model meas (.ref_clk(ref_clk), .var_gen_cmd(var_gen_cmd),
        .var_bus_cmd(var_bus_cmd), .cur_cmd(cur_cmd), .rpm_cmd(rpm_cmd), .freq_cmd(freq_cmd),
        .var_gen(var_gen), .var_bus(var_bus), .cur_a(cur_a), .cur_b(cur_b), .cur_c(cur_c),
        .speed_pickup_sensor(speed_pickup_sensor), .gen_freq(gen_freq));

    // block under test with a short evaluation tick
    prat_alarm_top #(.TICK_CYC(TC)) dut (.ref_clk(ref_clk), .rstn(rstn),
        .alarm_reset(alarm_reset), .var_gen(var_gen), .var_bus(var_bus),
        .gen_var_lvl(gen_var_lvl), .bus_var_lvl(bus_var_lvl), .gen_pre_dly(gen_pre_dly),
        .gen_alm_dly(gen_alm_dly), .bus_pre_dly(bus_pre_dly), .bus_alm_dly(bus_alm_dly),
        .cur_a(cur_a), .cur_b(cur_b), .cur_c(cur_c), .rated_cur(rated_cur),
        .imb_pre_lvl(imb_pre_lvl), .imb_alm_lvl(imb_alm_lvl), .imb_shift(imb_shift),
        .synchronizing(synchronizing), .permissive_mode(permissive_mode),
        .phases_in_sync(phases_in_sync), .close_request(close_request),
        .bias_at_limit(bias_at_limit), .bias_demand(bias_demand),
        .bias_responding(bias_responding), .bias_digital(bias_digital),
        .speed_pickup_sensor(speed_pickup_sensor), .gen_freq(gen_freq),
        .gen_poles(gen_poles), .action_cfg(action_cfg), .alarms(alarms),
        .worst_action(worst_action), .breaker_close(breaker_close));

    // clock
    always #4 ref_clk = ~ref_clk;

    // compare tasks for bits, values and elapsed cycles
    task automatic check_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: bit %b expected %b", $time, got, exp);
        end
    endtask : check_bit

    task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: value %h expected %h", $time, got, exp);
        end
    endtask : check_val

    task automatic check_time(input int got, input int lo, input int hi);
        checks_done++;
        if (got < lo || got > hi) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %0d cycles, window %0d..%0d", $time, got, lo, hi);
        end
    endtask : check_time

    // wait for one alarm bit and judge how long it took, in ticks
    task automatic wait_alarm(input int idx, input int ticks, input int tol);
        int n;
        n = 0;
        while (alarms[idx] !== 1'b1 && n < (ticks + tol) * TC + 8) begin
            @(negedge ref_clk);
            n++;
        end
        check_time(n, (ticks - tol) * TC - 2, (ticks + tol) * TC + 4);
    endtask : wait_alarm

    // pulse the controller reset for one clock
    task automatic clear_alarms();
        @(negedge ref_clk);
        alarm_reset = 1'b1;
        @(negedge ref_clk);
        alarm_reset = 1'b0;
        @(negedge ref_clk);
    endtask : clear_alarms

    // verdict and end of run
    task automatic finish_test();
        $display("checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test

    // hang guard
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 70000) begin
            miscompares++;
            finish_test();
        end
    end

    // main sequence
    initial begin
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        rstn = 1'b1;
        repeat (3) @(negedge ref_clk);
        check_val({1'b0, alarms}, 16'h0000);
        // broken excursion restarts the timer, then a full delay trips
        var_gen_cmd = 16'sd150;
        repeat (6) @(negedge ref_clk);
        var_gen_cmd = 16'sd50;
        repeat (2) @(negedge ref_clk);
        var_gen_cmd = 16'sd150;
        wait_alarm(0, 5, 1);
        repeat (2) @(negedge ref_clk);
        check_bit(alarms[1], 1'b0);
        check_val({14'h0, worst_action}, 16'h0001);
        var_gen_cmd = 16'sd0;
        repeat (10) @(negedge ref_clk);
        check_bit(alarms[0], 1'b1);
        clear_alarms();
        check_val({1'b0, alarms}, 16'h0000);
        // above the alarm level both trip on their own delays
        var_gen_cmd = 16'sd250;
        wait_alarm(1, 8, 1);
        check_bit(alarms[0], 1'b1);
        @(negedge ref_clk);
        check_val({14'h0, worst_action}, 16'h0003);
        // reverse on the generator, then import and export on the bus
        var_gen_cmd = -16'sd150;
        clear_alarms();
        wait_alarm(2, 5, 1);
        check_bit(alarms[0], 1'b0);
        var_gen_cmd = 16'sd0;
        var_bus_cmd = -16'sd250;
        clear_alarms();
        wait_alarm(7, 3, 1);
        wait_alarm(6, 9, 1);
        check_bit(alarms[4], 1'b0);
        var_bus_cmd = 16'sd150;
        clear_alarms();
        wait_alarm(4, 12, 1);
        var_bus_cmd = 16'sd0;
        // imbalance with rated zero: ratio 0, fixed 10 s times the clamped shift
        for (int k = 0; k < 3; k++) begin
            imb_shift = imb_d[k];
            cur_cmd = '{16'h01f4, 16'h01f4, 16'h01f4};
            clear_alarms();
            cur_cmd = imb_pat[k];
            wait_alarm(8, imb_t[k], 2);
            check_bit(alarms[9], 1'b0);
        end
        // imbalance on the curve at ratio two with shift 0.1
        rated_cur = 16'h0064;
        imb_shift = 10'h00a;
        imb_alm_lvl = 16'h0032;
        cur_cmd = '{16'h01f4, 16'h01f4, 16'h01f4};
        clear_alarms();
        cur_cmd = '{16'h00c8, 16'h0064, 16'h0096};
        wait_alarm(9, 703, 4);
        check_bit(alarms[8], 1'b1);
        cur_cmd = '{16'h01f4, 16'h01f4, 16'h01f4};
        // breaker close across every synchronizer combination
        for (int k = 0; k < 16; k++) begin
            {synchronizing, permissive_mode, phases_in_sync, close_request} = 4'(k);
            repeat (2) @(negedge ref_clk);
            check_bit(breaker_close, k[3] & k[1] & (k[2] | k[0]));
        end
        // analog bias limit with a mismatch that first sits on the margin
        freq_cmd = 16'h1324;
        bias_at_limit = 4'h1;
        bias_demand = 4'h4;
        bias_responding = 2'h3;
        clear_alarms();
        repeat (6000 * TC) @(negedge ref_clk);
        check_bit(alarms[14], 1'b0);
        freq_cmd = 16'h12c0;
        wait_alarm(10, 4000, 3);
        wait_alarm(14, 1000, 3);
        check_val({10'h0, alarms[13:11], alarms[9:8], 1'b0}, 16'h0000);
        // digital bias: demand with no response on speed only
        bias_at_limit = 4'h0;
        freq_cmd = 16'h1388;
        rpm_cmd = 16'h05dc;
        gen_poles = 8'h04;
        bias_digital = 1'b1;
        bias_demand = 4'ha;
        bias_responding = 2'h1;
        clear_alarms();
        wait_alarm(13, 10000, 3);
        check_val({12'h0, alarms[12:10], 1'b0}, 16'h0000);
        check_bit(alarms[14], 1'b0);
        finish_test();
    end
endmodule : testbench
